// File: cmhc_pkg.sv
package cmhc_pkg;
  typedef enum logic [1:0] {MODE_PROG, MODE_CONS, MODE_RDM} cmhc_mode_t;
  typedef enum logic [2:0] {SEQ_WAIT, SEQ_EVAL, SEQ_BOOT, SEQ_RESTART, SEQ_IDLE} cmhc_seq_t;

  localparam logic [2:0] KEY_OFF = 3'h0;
  localparam logic [2:0] KEY_LOCAL = 3'h1;
  localparam logic [2:0] KEY_SECURE = 3'h2;
  localparam logic [2:0] KEY_REMOTE = 3'h3;
  localparam logic [2:0] KEY_REMSEC = 3'h4;

  localparam logic [1:0] ACT_HALT = 2'h0;
  localparam logic [1:0] ACT_BOOT = 2'h1;
  localparam logic [1:0] ACT_HALT_RST = 2'h2;
  localparam logic [1:0] ACT_BOOT_RST = 2'h3;
  localparam logic [1:0] BOOT_ROM_TAPE = 2'h0;
  localparam logic [1:0] SEL_RESET = 2'h0;

  localparam logic [7:0] HC_CONSOLE = 8'h00;
  localparam logic [7:0] HC_SELFTEST = 8'h01;
  localparam logic [7:0] HC_ATTN = 8'h02;
  localparam logic [7:0] HC_NO_RPB = 8'h11;
  localparam logic [7:0] HC_NO_WARM = 8'h12;
  localparam logic [7:0] HC_BAD_ROM = 8'h14;
  localparam logic [7:0] HC_PWR_HALT = 8'h16;
  localparam logic [7:0] HC_UVERIFY = 8'hFF;

  localparam logic [7:0] CH_ATTN = 8'h10;
  localparam logic [7:0] CH_RDM = 8'h04;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_PROMPT = 8'h3E;
  localparam logic [7:0] CH_DIGIT = 8'h30;
  localparam logic [7:0] CH_LETTER = 8'h37;
  localparam logic [3:0] NIB_TEN = 4'hA;

  localparam logic [4:0] MSG_SP_IDX = 5'h08;
  localparam logic [4:0] MSG_CODE_HI = 5'h09;
  localparam logic [4:0] MSG_CODE_LO = 5'h0A;
  localparam logic [4:0] MSG_CR_IDX = 5'h0B;
  localparam logic [4:0] MSG_LF_IDX = 5'h0C;
  localparam logic [4:0] MSG_LAST = 5'h10;

  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
endpackage

// File: cmhc_hex_ascii.sv
`timescale 1ns/1ps
module cmhc_hex_ascii (
  input wire logic [3:0] nibble,
  output logic [7:0] ascii
);
  import cmhc_pkg::*;

  wire isLetter = (nibble >= NIB_TEN);

  assign ascii = (isLetter ? CH_LETTER : CH_DIGIT) + {4'h0, nibble};
endmodule

// File: cmhc_fifo.sv
`timescale 1ns/1ps
module cmhc_fifo #(
  parameter int WIDTH = cmhc_pkg::FIFO_WIDTH,
  parameter int DEPTH = cmhc_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gBadDepth
      $error("FIFO depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;

  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;

  assign inReady = (count != DEPTH[AW:0]);
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];

  always_ff @(posedge clock) begin
    if (doWrite) mem[wrPtr] <= inData;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) wrPtr <= wrPtr + 1'b1;
      if (doRead) rdPtr <= rdPtr + 1'b1;
      count <= count + {{AW{1'b0}}, doWrite} - {{AW{1'b0}}, doRead};
    end
  end
endmodule

// File: cmhc_console.sv
`timescale 1ns/1ps
module cmhc_console (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [2:0] keyPos,
  input wire logic [1:0] powerOnAction,
  input wire logic [1:0] bootSelect,
  input wire logic resetButton,
  input wire logic rdmFitted,
  input wire logic remoteGiveBack,
  input wire logic termRxValid,
  input wire logic [7:0] termRxData,
  input wire logic remRxValid,
  input wire logic [7:0] remRxData,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  output logic txToRemote,
  output logic cpuRxValid,
  output logic [7:0] cpuRxData,
  input wire logic cpuTxValid,
  input wire logic [7:0] cpuTxData,
  output logic cpuTxReady,
  input wire logic [31:0] pc,
  input wire logic cpuHalt,
  input wire logic [7:0] cpuHaltCode,
  input wire logic consoleHalt,
  input wire logic selfTestPass,
  input wire logic microVerifyFail,
  input wire logic csParityError,
  input wire logic resumeRun,
  output logic cmdValid,
  output logic [7:0] cmdData,
  output logic rdmRxValid,
  output logic [7:0] rdmRxData,
  input wire logic rdmExit,
  input wire logic rpbFound,
  input wire logic bootDone,
  input wire logic bootFailed,
  input wire logic restartDone,
  input wire logic restartFailed,
  output logic bootReq,
  output logic restartReq,
  output logic [1:0] bootRomSel,
  output logic bootFromTape,
  output logic haltReq,
  output logic powerCycle,
  output cmhc_pkg::cmhc_mode_t consoleMode,
  output logic [7:0] haltCode,
  output logic runLamp,
  output logic errorLampBright,
  output logic errorLampDim,
  output logic rdmEnable
);
  import cmhc_pkg::*;

  logic [1:0] rstPipe;
  wire rstn = rstPipe[1];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) rstPipe <= 2'h0;
    else rstPipe <= {rstPipe[0], 1'b1};
  end

  // Panel switches are levels; one register each so decisions see a steady copy
  logic [2:0] keyReg;
  logic [1:0] actReg;
  logic [1:0] selReg;
  logic buttonReg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      keyReg <= KEY_OFF;
      actReg <= ACT_HALT;
      selReg <= SEL_RESET;
      buttonReg <= 1'b1;
    end else begin
      keyReg <= keyPos;
      actReg <= powerOnAction;
      selReg <= bootSelect;
      buttonReg <= resetButton;
    end
  end

  cmhc_seq_t seq;
  cmhc_seq_t next_seq;
  cmhc_mode_t next_mode;
  logic errStop;
  logic msgBusy;
  logic [4:0] msgIdx;
  logic [31:0] pcWork;
  logic seqHalt;
  logic seqRun;
  logic seqBoot;
  logic seqRestart;
  logic [7:0] seqCode;

  wire seqBusy = (seq != SEQ_IDLE);
  wire inProg = (consoleMode == MODE_PROG);
  wire inCons = (consoleMode == MODE_CONS);
  wire inRdm = (consoleMode == MODE_RDM);

  wire keySecure = (keyReg == KEY_SECURE) || (keyReg == KEY_REMSEC);
  wire remoteLine = (keyReg == KEY_REMSEC) ||
    (keyReg == KEY_REMOTE && !remoteGiveBack);
  wire rdmAllowed = rdmFitted && (keyReg == KEY_REMOTE);

  // Local terminal is simply not heard while the remote line owns the console
  wire rxValid = remoteLine ? remRxValid : termRxValid;
  wire [7:0] rxByte = remoteLine ? remRxData : termRxData;

  wire cmdsBlocked = keySecure || errStop || seqBusy || msgBusy ||
    (keyReg == KEY_OFF);
  wire attnHit = rxValid && (rxByte == CH_ATTN) && !keySecure &&
    !errStop && !seqBusy;
  wire buttonHit = resetButton && !buttonReg && !keySecure;
  wire faultStop = csParityError && !errStop;

  wire rdmEnter = inCons && rxValid && (rxByte == CH_RDM) &&
    rdmAllowed && !cmdsBlocked;
  wire passChar = inProg && rxValid && !attnHit;
  wire cmdChar = inCons && rxValid && !cmdsBlocked && !attnHit && !rdmEnter;
  wire rdmChar = inRdm && rxValid && !attnHit;

  // Fault codes arrive from the processor with its halt; the rest are made here
  wire haltEvt = microVerifyFail || cpuHalt || attnHit || selfTestPass ||
    consoleHalt || seqHalt;
  wire [7:0] evCode = microVerifyFail ? HC_UVERIFY :
    cpuHalt ? cpuHaltCode :
    attnHit ? HC_ATTN :
    selfTestPass ? HC_SELFTEST :
    consoleHalt ? HC_CONSOLE :
    seqCode;

  always_comb begin
    next_seq = seq;
    seqHalt = 1'b0;
    seqRun = 1'b0;
    seqBoot = 1'b0;
    seqRestart = 1'b0;
    seqCode = HC_PWR_HALT;
    case (seq)
      SEQ_WAIT: next_seq = SEQ_EVAL;
      SEQ_EVAL: begin
        case (actReg)
          ACT_HALT: begin
            seqHalt = 1'b1;
            next_seq = SEQ_IDLE;
          end
          ACT_BOOT: begin
            seqBoot = 1'b1;
            next_seq = SEQ_BOOT;
          end
          default: begin
            if (rpbFound) begin
              seqRestart = 1'b1;
              next_seq = SEQ_RESTART;
            end else if (actReg == ACT_BOOT_RST) begin
              seqBoot = 1'b1;
              next_seq = SEQ_BOOT;
            end else begin
              seqHalt = 1'b1;
              seqCode = HC_NO_RPB;
              next_seq = SEQ_IDLE;
            end
          end
        endcase
      end
      SEQ_BOOT: begin
        if (bootDone) begin
          seqRun = 1'b1;
          next_seq = SEQ_IDLE;
        end else if (bootFailed) begin
          seqHalt = 1'b1;
          seqCode = HC_BAD_ROM;
          next_seq = SEQ_IDLE;
        end
      end
      SEQ_RESTART: begin
        if (restartDone) begin
          seqRun = 1'b1;
          next_seq = SEQ_IDLE;
        end else if (restartFailed && actReg == ACT_BOOT_RST) begin
          seqBoot = 1'b1;
          next_seq = SEQ_BOOT;
        end else if (restartFailed) begin
          seqHalt = 1'b1;
          seqCode = HC_NO_WARM;
          next_seq = SEQ_IDLE;
        end
      end
      SEQ_IDLE: next_seq = SEQ_IDLE;
      default: next_seq = SEQ_IDLE;
    endcase
    if (buttonHit) next_seq = SEQ_WAIT;
  end

  // Halt beats resume in the same cycle; a stopped machine never resumes
  always_comb begin
    next_mode = consoleMode;
    case (consoleMode)
      MODE_PROG: next_mode = MODE_PROG;
      MODE_CONS: begin
        if (rdmEnter) next_mode = MODE_RDM;
        else if (resumeRun && !cmdsBlocked) next_mode = MODE_PROG;
      end
      MODE_RDM: begin
        if (rdmExit || !rdmAllowed) next_mode = MODE_CONS;
      end
      default: next_mode = MODE_CONS;
    endcase
    if (seqRun && !errStop) next_mode = MODE_PROG;
    if (haltEvt || buttonHit || faultStop) next_mode = MODE_CONS;
  end

  // Parity stop is set-dominant; only a reset or accepted button clears it
  wire next_errStop = csParityError || (errStop && !buttonHit);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      seq <= SEQ_WAIT;
      consoleMode <= MODE_CONS;
      errStop <= 1'b0;
    end else begin
      seq <= next_seq;
      consoleMode <= next_mode;
      errStop <= next_errStop;
    end
  end

  // Halt message: eight PC digits, space, two code digits, CR, LF, four prompts
  logic [3:0] genNib;
  logic [7:0] genHex;
  logic [7:0] genChar;
  logic fifoInReady;

  assign genNib = (msgIdx == MSG_CODE_HI) ? haltCode[7:4] :
    (msgIdx == MSG_CODE_LO) ? haltCode[3:0] : pcWork[31:28];

  cmhc_hex_ascii uHex (
    .nibble(genNib),
    .ascii(genHex)
  );

  assign genChar = (msgIdx < MSG_SP_IDX) ? genHex :
    (msgIdx == MSG_SP_IDX) ? CH_SP :
    (msgIdx <= MSG_CODE_LO) ? genHex :
    (msgIdx == MSG_CR_IDX) ? CH_CR :
    (msgIdx == MSG_LF_IDX) ? CH_LF : CH_PROMPT;

  wire msgStep = msgBusy && fifoInReady;
  wire fifoInValid = msgBusy || cpuTxValid;
  wire [7:0] fifoInData = msgBusy ? genChar : cpuTxData;

  // Processor output waits behind the message so the two never interleave
  assign cpuTxReady = fifoInReady && !msgBusy;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      msgBusy <= 1'b0;
      msgIdx <= 5'h00;
      pcWork <= 32'h0000_0000;
      haltCode <= HC_CONSOLE;
    end else if (buttonHit) begin
      msgBusy <= 1'b0;
    end else if (haltEvt) begin
      msgBusy <= 1'b1;
      msgIdx <= 5'h00;
      pcWork <= pc;
      haltCode <= evCode;
    end else if (msgStep) begin
      msgIdx <= msgIdx + 5'h01;
      if (msgIdx < MSG_SP_IDX) pcWork <= {pcWork[27:0], 4'h0};
      if (msgIdx == MSG_LAST) msgBusy <= 1'b0;
    end
  end

  cmhc_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) uTxFifo (
    .clock(clock),
    .rstn(rstn),
    .inValid(fifoInValid),
    .inData(fifoInData),
    .inReady(fifoInReady),
    .outValid(txValid),
    .outData(txData),
    .outReady(txReady)
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cpuRxValid <= 1'b0;
      cmdValid <= 1'b0;
      rdmRxValid <= 1'b0;
    end else begin
      cpuRxValid <= passChar;
      cmdValid <= cmdChar;
      rdmRxValid <= rdmChar;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cpuRxData <= 8'h00;
      cmdData <= 8'h00;
      rdmRxData <= 8'h00;
    end else begin
      cpuRxData <= rxByte;
      cmdData <= rxByte;
      rdmRxData <= rxByte;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bootReq <= 1'b0;
      restartReq <= 1'b0;
      haltReq <= 1'b0;
      powerCycle <= 1'b0;
    end else begin
      bootReq <= seqBoot && !buttonHit;
      restartReq <= seqRestart && !buttonHit;
      haltReq <= attnHit || faultStop;
      powerCycle <= buttonHit;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bootRomSel <= SEL_RESET;
      bootFromTape <= 1'b0;
      txToRemote <= 1'b0;
      rdmEnable <= 1'b0;
    end else begin
      bootRomSel <= selReg;
      bootFromTape <= (selReg == BOOT_ROM_TAPE);
      txToRemote <= remoteLine;
      rdmEnable <= rdmAllowed;
    end
  end

  // Lamps follow next-state values so they change in step with the mode
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      runLamp <= 1'b0;
      errorLampBright <= 1'b0;
      errorLampDim <= 1'b0;
    end else begin
      runLamp <= (next_mode == MODE_PROG);
      errorLampBright <= next_errStop;
      errorLampDim <= !next_errStop;
    end
  end
endmodule

// File: cmhc_console_asserts.sv
`timescale 1ns/1ps
module cmhc_console_asserts (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [2:0] keyPos,
  input wire logic termRxValid,
  input wire logic [7:0] termRxData,
  input wire logic cpuRxValid,
  input wire logic [7:0] cpuRxData,
  input wire logic cmdValid,
  input wire logic cpuHalt,
  input wire logic [7:0] cpuHaltCode,
  input wire logic microVerifyFail,
  input wire logic csParityError,
  input wire logic powerCycle,
  input wire cmhc_pkg::cmhc_mode_t consoleMode,
  input wire logic [7:0] haltCode,
  input wire logic runLamp,
  input wire logic errorLampBright,
  input wire logic errorLampDim
);
  import cmhc_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  a_mode_code_legal: assert property (consoleMode != 2'h3)
    else $error("unused mode code entered");
  a_run_lamp_mode: assert property (runLamp == (consoleMode == MODE_PROG))
    else $error("run lamp disagrees with mode");
  a_halt_to_cons: assert property (cpuHalt && !microVerifyFail && !csParityError |=>
    consoleMode == MODE_CONS && haltCode == $past(cpuHaltCode))
    else $error("processor halt not reported");
  a_verify_code: assert property (microVerifyFail |=> haltCode == HC_UVERIFY)
    else $error("verify failure code wrong");
  a_prog_relay: assert property (termRxValid && termRxData != CH_ATTN && !cpuHalt
    && keyPos == KEY_LOCAL && consoleMode == MODE_PROG
    |=> cpuRxValid && cpuRxData == $past(termRxData))
    else $error("character not relayed");
  a_prog_no_cmd: assert property (consoleMode == MODE_PROG |=> !cmdValid)
    else $error("command taken in program mode");
  a_secure_reset: assert property (
    ((keyPos == KEY_SECURE) || (keyPos == KEY_REMSEC)) [*4] |-> !powerCycle)
    else $error("reset button honoured while secure");
  a_parity_stop: assert property ($rose(csParityError) |=> errorLampBright
    && !errorLampDim && consoleMode == MODE_CONS)
    else $error("parity stop not shown");
endmodule

// File: cmhc_terminal.sv
`timescale 1ns/1ps
module cmhc_terminal (
  input wire logic clock,
  input wire logic stall,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady = 1'h0,
  output logic rxValid = 1'h0,
  output logic [7:0] rxData = 8'h00
);
  logic [7:0] got[$];
  always @(negedge clock) begin
    txReady <= !stall;
  end
  always @(posedge clock) begin
    if (txValid && txReady) begin
      got.push_back(txData);
    end
  end
  task automatic send(input logic [7:0] ch);
    @(negedge clock);
    rxValid = 1'h1;
    rxData = ch;
    @(negedge clock);
    rxValid = 1'h0;
    // Idle line must not look like the last byte
    rxData = ~ch;
  endtask
endmodule

// File: cmhc_console_bench.sv
`timescale 1ns/1ps
module cmhc_console_bench;
  import cmhc_pkg::*;
  localparam logic [31:0] PC_VAL = 32'h1234ABCD;
  logic clock = 1'h0, rst_b = 1'h0, stall = 1'h0;
  logic [2:0] keyPos = KEY_LOCAL;
  logic [1:0] powerOnAction = ACT_HALT, bootSelect = BOOT_ROM_TAPE;
  logic resetButton = 1'h0, rdmFitted = 1'h0, remoteGiveBack = 1'h0, cpuTxValid = 1'h0;
  logic cpuHalt = 1'h0, consoleHalt = 1'h0, selfTestPass = 1'h0, microVerifyFail = 1'h0;
  logic csParityError = 1'h0, resumeRun = 1'h0, rdmExit = 1'h0, bootDone = 1'h0;
  logic [7:0] cpuTxData = 8'h00, cpuHaltCode = 8'h00;
  logic rpbFound = 1'h0, restartDone = 1'h0;
  logic restartReq, haltReq, powerCycle, rdmEnable;
  logic termRxValid, remRxValid, txValid, txToRemote, cpuRxValid, cpuTxReady, cmdValid;
  logic rdmRxValid, bootReq, bootFromTape, runLamp, errorLampBright, errorLampDim;
  logic termReady, remReady;
  logic [7:0] termRxData, remRxData, txData, cpuRxData, cmdData, rdmRxData, haltCode;
  logic [1:0] bootRomSel;
  cmhc_mode_t consoleMode;
  int mismatches = 0, compares = 0;

  cmhc_console i_dut (.clock, .rst_b, .keyPos, .powerOnAction, .bootSelect, .resetButton,
    .rdmFitted, .remoteGiveBack, .termRxValid, .termRxData, .remRxValid, .remRxData,
    .txValid, .txData, .txReady(txToRemote ? remReady : termReady), .txToRemote,
    .cpuRxValid, .cpuRxData, .cpuTxValid, .cpuTxData, .cpuTxReady, .pc(PC_VAL), .cpuHalt,
    .cpuHaltCode, .consoleHalt, .selfTestPass, .microVerifyFail, .csParityError, .resumeRun,
    .cmdValid, .cmdData, .rdmRxValid, .rdmRxData, .rdmExit, .rpbFound, .bootDone,
    .bootFailed(1'h0), .restartDone, .restartFailed(1'h0), .bootReq, .restartReq,
    .bootRomSel, .bootFromTape, .haltReq, .powerCycle, .consoleMode, .haltCode,
    .runLamp, .errorLampBright, .errorLampDim, .rdmEnable);
  cmhc_terminal i_term (.clock, .stall, .txValid(txValid && !txToRemote), .txData,
    .txReady(termReady), .rxValid(termRxValid), .rxData(termRxData));
  cmhc_terminal i_rem (.clock, .stall(1'h0), .txValid(txValid && txToRemote), .txData,
    .txReady(remReady), .rxValid(remRxValid), .rxData(remRxData));

  initial begin
    forever #25 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Every wait is bounded; running out ends the run
  task automatic tick(inout int n);
    @(negedge clock);
    n++;
    if (n > 3000) begin
      mismatches++;
      give_verdict();
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'h1;
    @(negedge clock);
    s = 1'h0;
  endtask

  task automatic power(input logic [1:0] act);
    powerOnAction = act;
    rst_b = 1'h0;
    repeat (10) @(negedge clock);
    rst_b = 1'h1;
  endtask

  // Returns while the one-cycle answer to the byte still stands
  task automatic feed(input bit rem, input logic [7:0] ch);
    if (rem)
      i_rem.send(ch);
    else
      i_term.send(ch);
  endtask

  task automatic wait_mode(input cmhc_mode_t m);
    int n = 0;
    while (consoleMode !== m) tick(n);
  endtask

  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < NIB_TEN) ? CH_DIGIT + v : CH_LETTER + v;
  endfunction

  task automatic expect_msg(input logic [7:0] code);
    logic [7:0] e[$];
    int n = 0;
    for (int i = 28; i >= 0; i -= 4) e.push_back(hx(PC_VAL[i+:4]));
    e = {e, CH_SP, hx(code[7:4]), hx(code[3:0]), CH_CR, CH_LF};
    e = {e, CH_PROMPT, CH_PROMPT, CH_PROMPT, CH_PROMPT};
    while (i_term.got.size() < 17) tick(n);
    repeat (4) @(negedge clock);
    chk(i_term.got.size(), 17);
    for (int k = 0; k < 17; k++) chk(i_term.got[k], e[k]);
    chk(consoleMode, MODE_CONS);
    chk(haltCode, code);
  endtask

  task automatic s_power_halt();
    power(ACT_HALT);
    expect_msg(HC_PWR_HALT);
    chk(errorLampDim, 1'h1);
  endtask

  task automatic s_codes();
    logic [7:0] codes[3] = '{HC_CONSOLE, HC_SELFTEST, HC_UVERIFY};
    for (int k = 0; k < 3; k++) begin
      i_term.got.delete();
      case (k)
        0: pulse(consoleHalt);
        1: pulse(selfTestPass);
        default: pulse(microVerifyFail);
      endcase
      expect_msg(codes[k]);
    end
  endtask

  task automatic s_keys();
    feed(0, 8'h45);
    chk(cmdData, 8'h45);
    keyPos = KEY_SECURE;
    feed(0, 8'h45);
    chk(cmdValid, 1'h0);
    keyPos = KEY_REMOTE;
    rdmFitted = 1'h1;
    feed(0, 8'h58);
    chk(cmdValid, 1'h0);
    feed(1, 8'h59);
    chk(cmdValid, 1'h1);
    feed(1, CH_RDM);
    chk(consoleMode, MODE_RDM);
    chk(rdmEnable, 1'h1);
    feed(1, 8'h51);
    chk(rdmRxData, 8'h51);
    chk(cmdValid, 1'h0);
    pulse(rdmExit);
    wait_mode(MODE_CONS);
    remoteGiveBack = 1'h1;
    feed(0, 8'h4C);
    chk(cmdValid, 1'h1);
    remoteGiveBack = 1'h0;
    keyPos = KEY_REMSEC;
    feed(1, 8'h52);
    chk(cmdValid, 1'h0);
    chk(txToRemote, 1'h1);
    pulse(resetButton);
    chk(powerCycle, 1'h0);
    repeat (10) @(negedge clock);
    chk(haltCode, HC_UVERIFY);
  endtask

  task automatic s_button();
    int n = 0;
    keyPos = KEY_LOCAL;
    powerOnAction = ACT_HALT_RST;
    i_term.got.delete();
    pulse(resetButton);
    chk(powerCycle, 1'h1);
    expect_msg(HC_NO_RPB);
    rpbFound = 1'h1;
    pulse(resetButton);
    while (restartReq !== 1'h1) tick(n);
    pulse(restartDone);
    wait_mode(MODE_PROG);
    chk(consoleMode, MODE_PROG);
    rpbFound = 1'h0;
  endtask

  task automatic s_boot(input logic [1:0] sel);
    int n = 0;
    bootSelect = sel;
    power(ACT_BOOT);
    while (bootReq !== 1'h1) tick(n);
    chk(bootRomSel, sel);
    chk(bootFromTape, sel == BOOT_ROM_TAPE);
    pulse(bootDone);
    wait_mode(MODE_PROG);
    chk(runLamp, 1'h1);
  endtask

  task automatic s_prog();
    int n = 0;
    feed(0, 8'h41);
    chk(cpuRxData, 8'h41);
    i_term.got.delete();
    @(negedge clock);
    cpuTxValid = 1'h1;
    cpuTxData = 8'h5A;
    while (cpuTxReady !== 1'h1) tick(n);
    @(negedge clock);
    cpuTxValid = 1'h0;
    cpuTxData = 8'hA5;
    while (i_term.got.size() < 1) tick(n);
    chk(i_term.got[0], 8'h5A);
    i_term.got.delete();
    feed(0, CH_ATTN);
    chk(cpuRxValid, 1'h0);
    chk(haltReq, 1'h1);
    expect_msg(HC_ATTN);
  endtask

  task automatic s_stall();
    pulse(resumeRun);
    wait_mode(MODE_PROG);
    stall = 1'h1;
    i_term.got.delete();
    cpuHaltCode = 8'h05;
    pulse(cpuHalt);
    repeat (40) @(negedge clock);
    chk(txValid, 1'h1);
    chk(cpuTxReady, 1'h0);
    stall = 1'h0;
    expect_msg(8'h05);
  endtask

  task automatic s_parity();
    int n = 0;
    pulse(resumeRun);
    wait_mode(MODE_PROG);
    keyPos = KEY_SECURE;
    feed(0, CH_ATTN);
    chk(consoleMode, MODE_PROG);
    keyPos = KEY_LOCAL;
    pulse(csParityError);
    chk(errorLampBright, 1'h1);
    feed(0, 8'h45);
    chk(cmdValid, 1'h0);
    pulse(resetButton);
    while (errorLampBright !== 1'h0) tick(n);
    chk(errorLampDim, 1'h1);
  endtask

  initial begin
    s_power_halt();
    s_codes();
    s_keys();
    s_button();
    s_boot(BOOT_ROM_TAPE);
    s_boot(2'h2);
    s_prog();
    s_stall();
    s_parity();
    give_verdict();
  end
endmodule

bind cmhc_console cmhc_console_asserts i_chk (.clock, .rst_b, .keyPos, .termRxValid,
  .termRxData, .cpuRxValid, .cpuRxData, .cmdValid, .cpuHalt, .cpuHaltCode,
  .microVerifyFail, .csParityError, .powerCycle, .consoleMode, .haltCode, .runLamp,
  .errorLampBright, .errorLampDim);
